// ---- src/fr_cond.sv ----
module fr_cond
	import fr_pkg::*;
(
	input fr_cond_t cond,
	input logic [31:0] flags,
	output logic take
);

	logic carry, zero, sign, ovf, parity, base, negate;

	// Each condition pair shares one base test; the negated member inverts it.
	always_comb
	begin
		carry = flags[FLAG_CARRY];
		zero = flags[FLAG_ZERO];
		sign = flags[FLAG_SIGN];
		ovf = flags[FLAG_OVERFLOW];
		parity = flags[FLAG_PARITY];
		negate = 1'b0;
		case (cond)
			CC_O, CC_NO: base = ovf;
			CC_B, CC_AE: base = carry;
			CC_E, CC_NE: base = zero;
			CC_BE, CC_A: base = carry | zero;
			CC_S, CC_NS: base = sign;
			CC_P, CC_NP: base = parity;
			CC_L, CC_GE: base = sign ^ ovf;
			CC_LE, CC_G: base = (sign ^ ovf) | zero;
			default: base = 1'b0;
		endcase
		case (cond)
			CC_NO, CC_AE, CC_NE, CC_A, CC_NS, CC_NP, CC_GE, CC_G: negate = 1'b1;
			default: negate = 1'b0;
		endcase
		// One code per condition, so alias names cannot diverge.
		take = base ^ negate;
	end

endmodule

// ---- src/fr_core.sv ----
module fr_core
	import fr_pkg::*;
(
	input logic ref_clk,
	input logic sys_rst,
	input logic ce,
	input logic cmd_valid,
	input fr_cmd_t cmd,
	output logic cmd_ready,
	output logic done,
	output logic moved,
	output fr_mem_req_t mem,
	input logic mem_ack,
	input logic [63:0] mem_rdata,
	input logic [REG_ADDR_W-1:0] reg_addr,
	input logic [31:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	output logic [31:0] reg_rdata
);

	fr_state_t st_reg;
	fr_state_t st_next;
	logic accept, legal, take, wr_in_mem;
	logic [2:0] wr_idx, blk, ridx;
	logic [31:0] src_val, src_hi, wr_new, wr_merged, mem_addr_calc, rd_val;
	fr_size_t wr_size;
	// Writes one general, segment, control or debug destination register, or a general register pair for a quadword.
	function automatic fr_state_t put_dst(fr_state_t s, fr_kind_t k, logic [2:0] i,
		logic [31:0] merged, logic [31:0] raw, logic [31:0] hi, fr_size_t sz);
		fr_state_t r;
		r = s;
		case (k)
			K_GPR:
			begin
				r.gpr[i] = merged;
				if (sz == SZ_QWORD)
					r.gpr[i + 3'h1] = hi;
			end
			K_SEG: r.seg[i] = raw[15:0];
			K_CTL: r.ctl[i] = raw;
			K_DBG: r.dbg[i] = raw;
			default: r = s;
		endcase
		return r;
	endfunction

	fr_cond u_cond (
		.cond(cmd.cond),
		.flags(st_reg.flags),
		.take(take)
	);
	fr_merge u_merge (
		.old_val(st_reg.gpr[wr_idx]),
		.new_val(wr_new),
		.size(wr_size),
		.merged(wr_merged)
	);

	// Source operand fetch and address forming from a base register.
	always_comb
	begin
		src_hi = st_reg.gpr[cmd.src_idx + 3'h1];
		mem_addr_calc = st_reg.gpr[cmd.base_idx] + cmd.disp;
		case (cmd.src_kind)
			K_GPR: src_val = st_reg.gpr[cmd.src_idx];
			K_SEG: src_val = {16'h0000, st_reg.seg[cmd.src_idx]};
			K_IMM: src_val = cmd.imm;
			K_CTL: src_val = st_reg.ctl[cmd.src_idx];
			K_DBG: src_val = st_reg.dbg[cmd.src_idx];
			default: src_val = 32'h0000_0000;
		endcase
	end

	// Operand path legality; illegal combinations are refused as a fault.
	always_comb
	begin
		legal = 1'b1;
		case (cmd.op)
			OP_MOVE:
			begin
				if (cmd.src_kind == K_MEM && cmd.dst_kind == K_MEM)
					legal = 1'b0;
				if (cmd.src_kind == K_SEG && cmd.dst_kind == K_SEG)
					legal = 1'b0;
				if (cmd.dst_kind == K_IMM)
					legal = 1'b0;
				if ((cmd.src_kind == K_CTL || cmd.src_kind == K_DBG) && cmd.dst_kind != K_GPR)
					legal = 1'b0;
				if ((cmd.dst_kind == K_CTL || cmd.dst_kind == K_DBG) && cmd.src_kind != K_GPR)
					legal = 1'b0;
				if (cmd.src_kind == K_SEG && cmd.src_idx >= 3'(NUM_SEG))
					legal = 1'b0;
				if (cmd.dst_kind == K_SEG && cmd.dst_idx >= 3'(NUM_SEG))
					legal = 1'b0;
				if (cmd.size == SZ_QWORD && !((cmd.src_kind == K_GPR || cmd.src_kind == K_MEM)
					&& (cmd.dst_kind == K_GPR || cmd.dst_kind == K_MEM)))
					legal = 1'b0;
			end
			OP_CMOVE:
			begin
				if (cmd.dst_kind != K_GPR || !(cmd.src_kind == K_GPR || cmd.src_kind == K_MEM))
					legal = 1'b0;
				if (!(cmd.size == SZ_WORD || cmd.size == SZ_DWORD))
					legal = 1'b0;
			end
			OP_NOP, OP_RELEASE: legal = 1'b1;
			OP_IDENT:
				if (cmd.dst_kind != K_GPR)
					legal = 1'b0;
			default: legal = 1'b0;
		endcase
	end

	// Write-port selection for the general register merge.
	always_comb
	begin
		wr_in_mem = (st_reg.state == ST_MEM);
		wr_idx = wr_in_mem ? st_reg.cmd.dst_idx : cmd.dst_idx;
		if (wr_in_mem)
		begin
			wr_size = st_reg.cmd.size;
			wr_new = mem_rdata[31:0];
		end
		else if (cmd.op == OP_IDENT)
		begin
			wr_size = SZ_DWORD;
			wr_new = FEATURE_WORD;
		end
		else
		begin
			wr_size = cmd.size;
			wr_new = src_val;
		end
	end

	// Register bus read decode.
	always_comb
	begin
		blk = reg_addr[7:5];
		ridx = reg_addr[4:2];
		rd_val = 32'h0000_0000;
		if (blk == REG_GPR_BASE[7:5])
			rd_val = st_reg.gpr[ridx];
		else if (blk == REG_SEG_BASE[7:5] && ridx < 3'(NUM_SEG))
			rd_val = {16'h0000, st_reg.seg[ridx]};
		else if (blk == REG_CTL_BASE[7:5])
			rd_val = st_reg.ctl[ridx];
		else if (blk == REG_DBG_BASE[7:5])
			rd_val = st_reg.dbg[ridx];
		else if (reg_addr == REG_FLAGS)
			rd_val = st_reg.flags;
		else if (reg_addr == REG_IP)
			rd_val = st_reg.ip;
		else if (reg_addr == REG_FEATURE)
			rd_val = FEATURE_WORD;
		else if (reg_addr == REG_STATUS)
		begin
			rd_val[STAT_BUSY_BIT] = !st_reg.ready;
			rd_val[STAT_ERR_BIT] = st_reg.err;
			rd_val[STAT_TAKEN_BIT] = st_reg.moved;
		end
	end

	// A command is taken only while the core is enabled and idle.
	assign accept = ce && cmd_valid && st_reg.ready;
	// Next state: bus writes first, so engine updates win on a collision.
	always_comb
	begin
		st_next = st_reg;
		st_next.done = 1'b0;
		st_next.rd_data = 32'h0000_0000;
		if (reg_rd)
			st_next.rd_data = rd_val;
		if (reg_wr)
		begin
			if (blk == REG_GPR_BASE[7:5])
				st_next.gpr[ridx] = reg_wdata;
			else if (blk == REG_SEG_BASE[7:5] && ridx < 3'(NUM_SEG))
				st_next.seg[ridx] = reg_wdata[15:0];
			else if (blk == REG_CTL_BASE[7:5])
				st_next.ctl[ridx] = reg_wdata;
			else if (blk == REG_DBG_BASE[7:5])
				st_next.dbg[ridx] = reg_wdata;
			else if (reg_addr == REG_FLAGS)
				st_next.flags = reg_wdata;
			else if (reg_addr == REG_IP)
				st_next.ip = reg_wdata;
			else if (reg_addr == REG_STATUS && reg_wdata[STAT_ERR_BIT])
				st_next.err = 1'b0;
		end
		case (st_reg.state)
			ST_IDLE:
				if (cmd_valid)
				begin
					st_next.cmd = cmd;
					st_next.moved = 1'b0;
					if (!legal)
					begin
						st_next.err = 1'b1;
						st_next.done = 1'b1;
					end
					else if (cmd.op == OP_RELEASE)
					begin
						// Copy first; the pop then reads the old frame slot.
						st_next.gpr[GPR_SP] = st_reg.gpr[GPR_FP];
						st_next.mem.req = 1'b1;
						st_next.mem.we = 1'b0;
						st_next.mem.size = SZ_DWORD;
						st_next.mem.addr = st_reg.gpr[GPR_FP];
						st_next.state = ST_REL_POP;
						st_next.ready = 1'b0;
					end
					else if (cmd.src_kind == K_MEM && cmd.op inside {OP_MOVE, OP_CMOVE})
					begin
						// A conditional load still reads; only the write is gated.
						st_next.cond_ok = (cmd.op != OP_CMOVE) || take;
						st_next.mem.req = 1'b1;
						st_next.mem.we = 1'b0;
						st_next.mem.size = cmd.size;
						st_next.mem.addr = mem_addr_calc;
						st_next.state = ST_MEM;
						st_next.ready = 1'b0;
					end
					else if (cmd.dst_kind == K_MEM && cmd.op == OP_MOVE)
					begin
						st_next.cond_ok = 1'b1;
						st_next.mem.req = 1'b1;
						st_next.mem.we = 1'b1;
						st_next.mem.size = cmd.size;
						st_next.mem.addr = mem_addr_calc;
						st_next.mem.wdata = {(cmd.size == SZ_QWORD) ? src_hi : 32'h0000_0000,
							src_val};
						st_next.state = ST_MEM;
						st_next.ready = 1'b0;
					end
					else
					begin
						if (cmd.op == OP_IDENT || cmd.op == OP_MOVE || (cmd.op == OP_CMOVE && take))
						begin
							st_next = put_dst(st_next, cmd.dst_kind, cmd.dst_idx, wr_merged,
								src_val, src_hi, wr_size);
							st_next.moved = (cmd.op != OP_IDENT);
						end
						// A false condition only advances the pointer.
						st_next.ip = st_reg.ip + {28'h0000000, cmd.len};
						st_next.done = 1'b1;
					end
				end
			ST_MEM:
				if (mem_ack)
				begin
					if (!st_reg.mem.we && st_reg.cond_ok)
						st_next = put_dst(st_next, st_reg.cmd.dst_kind, st_reg.cmd.dst_idx,
							wr_merged, mem_rdata[31:0], mem_rdata[63:32],
							st_reg.cmd.size);
					st_next.moved = st_reg.cond_ok;
					st_next.mem.req = 1'b0;
					st_next.ip = st_reg.ip + {28'h0000000, st_reg.cmd.len};
					st_next.done = 1'b1;
					st_next.ready = 1'b1;
					st_next.state = ST_IDLE;
				end
			ST_REL_POP:
				if (mem_ack)
				begin
					st_next.gpr[GPR_FP] = mem_rdata[31:0];
					st_next.gpr[GPR_SP] = st_reg.gpr[GPR_SP] + FRAME_POP_BYTES;
					st_next.mem.req = 1'b0;
					st_next.ip = st_reg.ip + {28'h0000000, st_reg.cmd.len};
					st_next.done = 1'b1;
					st_next.ready = 1'b1;
					st_next.state = ST_IDLE;
				end
			default: st_next.state = ST_IDLE;
		endcase
	end

	// State register; the clock enable freezes everything except the synchronous reset, which acts even with it low.
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			st_reg <= '0;
			st_reg.ready <= 1'b1;
			st_reg.flags <= FLAGS_RESET;
			st_reg.ip <= IP_RESET;
		end
		else if (ce)
			st_reg <= st_next;
	end
	// Every output is a field of the state register.
	assign cmd_ready = st_reg.ready;
	assign done = st_reg.done;
	assign moved = st_reg.moved;
	assign mem = st_reg.mem;
	assign reg_rdata = st_reg.rd_data;
	a_release_sp_copy: assert property (@(posedge ref_clk) disable iff (sys_rst)
		accept && legal && cmd.op == OP_RELEASE |=> st_reg.gpr[GPR_SP] == $past(st_reg.gpr[GPR_FP])
		&& st_reg.mem.req && !st_reg.mem.we && st_reg.mem.addr == $past(st_reg.gpr[GPR_FP]))
		else $error("Release did not copy frame pointer first.");
	a_release_pop: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ce && st_reg.state == ST_REL_POP && mem_ack |=> st_reg.gpr[GPR_FP] == $past(mem_rdata[31:0])
		&& st_reg.gpr[GPR_SP] == $past(st_reg.gpr[GPR_SP]) + FRAME_POP_BYTES && done && cmd_ready)
		else $error("Release pop result wrong.");
	a_flags_kept: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!sys_rst && !(ce && reg_wr && reg_addr == REG_FLAGS) |=> $stable(st_reg.flags))
		else $error("Flags changed without a bus write.");
	a_cmove_false_keep: assert property (@(posedge ref_clk) disable iff (sys_rst)
		accept && legal && !reg_wr && cmd.op == OP_CMOVE && cmd.src_kind == K_GPR && !take
		|=> $stable(st_reg.gpr) && done && !moved
		&& st_reg.ip == $past(st_reg.ip) + {28'h0000000, st_reg.cmd.len})
		else $error("False conditional move changed destination.");
	a_cmove_true_move: assert property (@(posedge ref_clk) disable iff (sys_rst)
		accept && legal && cmd.op == OP_CMOVE && cmd.src_kind == K_GPR && take
		&& cmd.size == SZ_DWORD |=> st_reg.gpr[st_reg.cmd.dst_idx] == $past(src_val) && moved)
		else $error("True conditional move lost data.");
	a_illegal_refused: assert property (@(posedge ref_clk) disable iff (sys_rst)
		accept && !legal |=> st_reg.err && !st_reg.mem.req && cmd_ready && done
		##1 (!done || $past(accept) || !$past(ce)))
		else $error("Illegal move not refused.");
	a_ident_feature: assert property (@(posedge ref_clk) disable iff (sys_rst)
		accept && legal && cmd.op == OP_IDENT |=> st_reg.gpr[st_reg.cmd.dst_idx][FEAT_CMOVE_BIT])
		else $error("Identify did not report conditional move.");
	a_imm_to_gpr: assert property (@(posedge ref_clk) disable iff (sys_rst)
		accept && legal && cmd.op == OP_MOVE && cmd.src_kind == K_IMM && cmd.dst_kind == K_GPR
		&& cmd.size == SZ_DWORD |=> st_reg.gpr[st_reg.cmd.dst_idx] == $past(cmd.imm))
		else $error("Immediate not written to register.");
	a_store_request: assert property (@(posedge ref_clk) disable iff (sys_rst)
		accept && legal && cmd.op == OP_MOVE && cmd.src_kind == K_GPR && cmd.dst_kind == K_MEM
		|=> mem.req && mem.we && mem.wdata[31:0] == $past(src_val) && !cmd_ready)
		else $error("Store request malformed.");
	a_mem_complete: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ce && st_reg.state == ST_MEM && mem_ack |=> done && cmd_ready && !mem.req)
		else $error("Memory transfer did not complete.");

endmodule

// ---- src/fr_merge.sv ----
module fr_merge
	import fr_pkg::*;
(
	input logic [31:0] old_val,
	input logic [31:0] new_val,
	input fr_size_t size,
	output logic [31:0] merged
);

	// Narrow writes keep the untouched upper bits of the destination.
	always_comb
	begin
		case (size)
			SZ_BYTE: merged = {old_val[31:8], new_val[7:0]};
			SZ_WORD: merged = {old_val[31:16], new_val[15:0]};
			default: merged = new_val;
		endcase
	end

endmodule

// ---- src/fr_pkg.sv ----
package fr_pkg;

	localparam int NUM_GPR = 8;
	localparam int NUM_SEG = 6;
	localparam int NUM_CTL = 8;
	localparam int NUM_DBG = 8;
	localparam int REG_ADDR_W = 8;

	// Register map, byte addresses of aligned 32-bit words.
	localparam logic [7:0] REG_GPR_BASE = 8'h00;
	localparam logic [7:0] REG_SEG_BASE = 8'h20;
	localparam logic [7:0] REG_FLAGS = 8'h40;
	localparam logic [7:0] REG_IP = 8'h44;
	localparam logic [7:0] REG_FEATURE = 8'h48;
	localparam logic [7:0] REG_STATUS = 8'h4c;
	localparam logic [7:0] REG_CTL_BASE = 8'h80;
	localparam logic [7:0] REG_DBG_BASE = 8'ha0;

	// Status bits.
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_ERR_BIT = 1;
	localparam int STAT_TAKEN_BIT = 2;

	// Flag positions inside the flags register.
	localparam int FLAG_CARRY = 0;
	localparam int FLAG_PARITY = 1;
	localparam int FLAG_ZERO = 2;
	localparam int FLAG_SIGN = 3;
	localparam int FLAG_OVERFLOW = 4;

	// Feature word returned by the identify operation.
	localparam int FEAT_CMOVE_BIT = 0;
	localparam logic [31:0] FEATURE_WORD = 32'h0000_0001;

	// Stack roles of two general-purpose registers.
	localparam logic [2:0] GPR_SP = 3'h4;
	localparam logic [2:0] GPR_FP = 3'h5;
	localparam logic [31:0] FRAME_POP_BYTES = 32'h0000_0004;

	// Reset values.
	localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;
	localparam logic [31:0] IP_RESET = 32'h0000_0000;

	typedef enum logic [2:0] {OP_NOP, OP_MOVE, OP_CMOVE, OP_RELEASE, OP_IDENT} fr_op_t;
	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_DWORD, SZ_QWORD} fr_size_t;
	typedef enum logic [2:0] {K_GPR, K_SEG, K_MEM, K_IMM, K_CTL, K_DBG} fr_kind_t;
	typedef enum logic [3:0] {
		CC_O, CC_NO, CC_B, CC_AE, CC_E, CC_NE, CC_BE, CC_A,
		CC_S, CC_NS, CC_P, CC_NP, CC_L, CC_GE, CC_LE, CC_G
	} fr_cond_t;
	typedef enum logic [1:0] {ST_IDLE, ST_MEM, ST_REL_POP} fr_fsm_t;

	// One decoded operation as handed to the unit.
	typedef struct packed {
		fr_op_t op;
		fr_size_t size;
		fr_kind_t dst_kind;
		logic [2:0] dst_idx;
		fr_kind_t src_kind;
		logic [2:0] src_idx;
		fr_cond_t cond;
		logic [2:0] base_idx;
		logic [31:0] disp;
		logic [31:0] imm;
		logic [3:0] len;
	} fr_cmd_t;

	// Request toward data and stack memory.
	typedef struct packed {
		logic req;
		logic we;
		fr_size_t size;
		logic [31:0] addr;
		logic [63:0] wdata;
	} fr_mem_req_t;

	// Whole state of the core.
	typedef struct packed {
		fr_fsm_t state;
		logic ready;
		logic done;
		logic moved;
		logic err;
		logic cond_ok;
		fr_cmd_t cmd;
		fr_mem_req_t mem;
		logic [31:0] rd_data;
		logic [NUM_GPR-1:0][31:0] gpr;
		logic [NUM_SEG-1:0][15:0] seg;
		logic [31:0] flags;
		logic [31:0] ip;
		logic [NUM_CTL-1:0][31:0] ctl;
		logic [NUM_DBG-1:0][31:0] dbg;
	} fr_state_t;

endpackage

// ---- verification/fr_mem_model.sv ----
// Behavioural data and stack memory on the far side of the core's memory port.
module fr_mem_model
	import fr_pkg::*;
(
	input logic ref_clk,
	input logic sys_rst,
	input fr_mem_req_t mem,
	input logic [3:0] delay,
	output logic mem_ack,
	output logic [63:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [31:0] words [64];
	logic [3:0] wait_cnt;
	logic [5:0] idx;

	// Word index of the request; only aligned accesses are modelled.
	assign idx = mem.addr[7:2];

	// Answers each request after delay cycles; read data outside an answer is scrambled.
	always @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			mem_ack <= 1'b0;
			wait_cnt <= 4'h0;
			mem_rdata <= 64'h0;
		end
		else if (mem_ack)
		begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end
		else if (mem.req && wait_cnt != delay)
		begin
			wait_cnt <= wait_cnt + 4'h1;
			mem_rdata <= ~mem_rdata;
		end
		else if (mem.req)
		begin
			mem_ack <= 1'b1;
			wait_cnt <= 4'h0;
			mem_rdata <= {words[idx + 6'h1], words[idx]};
			if (mem.we)
			begin
				case (mem.size)
					SZ_BYTE: words[idx][7:0] <= mem.wdata[7:0];
					SZ_WORD: words[idx][15:0] <= mem.wdata[15:0];
					SZ_DWORD: words[idx] <= mem.wdata[31:0];
					default:
					begin
						words[idx] <= mem.wdata[31:0];
						words[idx + 6'h1] <= mem.wdata[63:32];
					end
				endcase
			end
		end
		else
			mem_rdata <= ~mem_rdata;
	end
endmodule

// ---- verification/testbench.sv ----
// Self-checking bench for the move and frame release core.
module testbench
	import fr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [31:0] flags;
		logic [15:0] taken;
	} fr_row_t;

	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic ce = 1'b1;
	logic cmd_valid = 1'b0;
	fr_cmd_t cmd = '0;
	logic cmd_ready, done, moved, mem_ack;
	fr_mem_req_t mem;
	logic [63:0] mem_rdata;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [3:0] delay = 4'h0;
	logic [31:0] exp_ip = 32'h0;
	logic [31:0] last_addr = 32'h0;
	int fail_count = 0;
	int total_checks = 0;
	int cycles = 0;
	// Each row holds a flag setting and, per condition code, whether the move happens.
	fr_row_t rows [7] = '{
		'{32'h0000_0000, 16'haaaa},
		'{32'h0000_0001, 16'haa66},
		'{32'h0000_0002, 16'ha6aa},
		'{32'h0000_0004, 16'h6a5a},
		'{32'h0000_0008, 16'h59aa},
		'{32'h0000_0010, 16'h5aa9},
		'{32'h0000_0018, 16'ha9a9}
	};

	fr_core fr_core_inst (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_ready(cmd_ready), .done(done), .moved(moved), .mem(mem), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata)
	);

	fr_mem_model fr_mem_model_inst (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .mem(mem), .delay(delay),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata)
	);

	// Clock of 4 ns period.
	always #2 ref_clk = ~ref_clk;

	// Remembers the address of the last answered memory request.
	always @(posedge ref_clk)
	begin
		if (mem.req && mem_ack)
			last_addr <= mem.addr;
	end

	// Cuts a hang short.
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			$display("ERROR t=%0t cycles %h limit %h", $time, cycles, 30000);
			fail_count++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		if (fail_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	function automatic logic [7:0] ga(input int n);
		return REG_GPR_BASE + 8'(4 * n);
	endfunction

	function automatic fr_cmd_t mk(fr_op_t op, fr_size_t sz, fr_kind_t dk, int di, fr_kind_t sk,
		int si, fr_cond_t cc, logic [31:0] disp, logic [31:0] imm);
		return '{op, sz, dk, 3'(di), sk, 3'(si), cc, 3'h7, disp, imm, 4'h3};
	endfunction

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask

	// Offers one operation, waits for acceptance and then for completion.
	task automatic run(input fr_cmd_t c, input logic legal);
		int n;
		n = 0;
		@(posedge ref_clk);
		cmd_valid <= 1'b1;
		cmd <= c;
		do @(posedge ref_clk); while (cmd_ready !== 1'b1 && ++n < 50);
		cmd_valid <= 1'b0;
		n = 0;
		do @(posedge ref_clk); while (done !== 1'b1 && ++n < 100);
		if (n >= 100)
		begin
			fail_count++;
			$display("ERROR t=%0t done %h exp %h", $time, done, 1'b1);
		end
		if (legal)
			exp_ip = exp_ip + 32'h3;
	endtask

	// Main sequence: reset, condition table, then hand-written cases.
	initial
	begin
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		#1;
		chk({31'h0, cmd_ready}, 32'h1);
		rd_chk(REG_FLAGS, 32'h0);
		rd_chk(REG_IP, 32'h0);
		rd_chk(ga(5), 32'h0);
		rd_chk(REG_FEATURE, 32'h0000_0001);
		wr(8'hfc, 32'hffff_ffff);
		rd_chk(8'hfc, 32'h0);
		wr(ga(2), 32'hcafe_0002);
		foreach (rows[r])
			for (int c = 0; c < 16; c++)
			begin
				wr(REG_FLAGS, rows[r].flags);
				wr(ga(1), 32'h1111_0000 + 32'(c));
				run(mk(OP_CMOVE, SZ_DWORD, K_GPR, 1, K_GPR, 2, fr_cond_t'(c), 0, 0), 1'b1);
				rd_chk(ga(1), rows[r].taken[c] ? 32'hcafe_0002 : 32'h1111_0000 + 32'(c));
				chk({31'h0, moved}, {31'h0, rows[r].taken[c]});
				rd_chk(REG_FLAGS, rows[r].flags);
			end
		delay <= 4'h3;
		fr_mem_model_inst.words[16] = 32'h1234_5678;
		fr_mem_model_inst.words[17] = 32'ha5a5_0f0f;
		fr_mem_model_inst.words[18] = 32'hdead_beef;
		fr_mem_model_inst.words[20] = 32'h0000_1111;
		fr_mem_model_inst.words[21] = 32'h2222_0000;
		wr(ga(5), 32'h40);
		wr(ga(4), 32'h10);
		run(mk(OP_RELEASE, SZ_DWORD, K_GPR, 0, K_GPR, 0, CC_O, 0, 0), 1'b1);
		chk(last_addr, 32'h40);
		rd_chk(ga(5), 32'h1234_5678);
		rd_chk(ga(4), 32'h44);
		run(mk(OP_MOVE, SZ_DWORD, K_GPR, 3, K_MEM, 0, CC_O, 32'h44, 0), 1'b1);
		rd_chk(ga(3), 32'ha5a5_0f0f);
		run(mk(OP_MOVE, SZ_WORD, K_SEG, 2, K_MEM, 0, CC_O, 32'h44, 0), 1'b1);
		rd_chk(REG_SEG_BASE + 8'h08, 32'h0000_0f0f);
		run(mk(OP_MOVE, SZ_WORD, K_MEM, 0, K_SEG, 2, CC_O, 32'h48, 0), 1'b1);
		chk(fr_mem_model_inst.words[18], 32'hdead_0f0f);
		run(mk(OP_MOVE, SZ_DWORD, K_MEM, 0, K_GPR, 3, CC_O, 32'h4c, 0), 1'b1);
		chk(fr_mem_model_inst.words[19], 32'ha5a5_0f0f);
		run(mk(OP_MOVE, SZ_QWORD, K_GPR, 0, K_MEM, 0, CC_O, 32'h50, 0), 1'b1);
		rd_chk(ga(0), 32'h0000_1111);
		rd_chk(ga(1), 32'h2222_0000);
		wr(ga(1), 32'h1111_1111);
		run(mk(OP_MOVE, SZ_BYTE, K_GPR, 1, K_GPR, 3, CC_O, 0, 0), 1'b1);
		rd_chk(ga(1), 32'h1111_110f);
		run(mk(OP_MOVE, SZ_DWORD, K_GPR, 2, K_IMM, 0, CC_O, 0, 32'h0bad_f00d), 1'b1);
		rd_chk(ga(2), 32'h0bad_f00d);
		run(mk(OP_MOVE, SZ_DWORD, K_MEM, 0, K_IMM, 0, CC_O, 32'h58, 32'h7777_8888), 1'b1);
		chk(fr_mem_model_inst.words[22], 32'h7777_8888);
		wr(ga(3), 32'h1234_abcd);
		run(mk(OP_MOVE, SZ_WORD, K_SEG, 5, K_GPR, 3, CC_O, 0, 0), 1'b1);
		rd_chk(REG_SEG_BASE + 8'h14, 32'h0000_abcd);
		run(mk(OP_MOVE, SZ_DWORD, K_GPR, 1, K_SEG, 5, CC_O, 0, 0), 1'b1);
		rd_chk(ga(1), 32'h0000_abcd);
		run(mk(OP_MOVE, SZ_DWORD, K_CTL, 2, K_GPR, 3, CC_O, 0, 0), 1'b1);
		rd_chk(REG_CTL_BASE + 8'h08, 32'h1234_abcd);
		run(mk(OP_MOVE, SZ_DWORD, K_GPR, 1, K_CTL, 2, CC_O, 0, 0), 1'b1);
		rd_chk(ga(1), 32'h1234_abcd);
		wr(REG_DBG_BASE + 8'h0c, 32'h5555_aaaa);
		run(mk(OP_MOVE, SZ_DWORD, K_GPR, 6, K_DBG, 3, CC_O, 0, 0), 1'b1);
		rd_chk(ga(6), 32'h5555_aaaa);
		run(mk(OP_MOVE, SZ_DWORD, K_MEM, 0, K_MEM, 0, CC_O, 32'h60, 0), 1'b0);
		run(mk(OP_MOVE, SZ_WORD, K_SEG, 1, K_SEG, 2, CC_O, 0, 0), 1'b0);
		rd_chk(REG_IP, exp_ip);
		rd_chk(REG_SEG_BASE + 8'h04, 32'h0);
		rd_chk(REG_STATUS, 32'h2);
		wr(REG_STATUS, 32'h2);
		rd_chk(REG_STATUS, 32'h0);
		run(mk(OP_IDENT, SZ_DWORD, K_GPR, 1, K_GPR, 0, CC_O, 0, 0), 1'b1);
		rd_chk(ga(1), 32'h0000_0001);
		wr(REG_FLAGS, 32'h0);
		run(mk(OP_CMOVE, SZ_WORD, K_GPR, 6, K_MEM, 0, CC_E, 32'h40, 0), 1'b1);
		rd_chk(ga(6), 32'h5555_aaaa);
		run(mk(OP_CMOVE, SZ_WORD, K_GPR, 6, K_MEM, 0, CC_NE, 32'h40, 0), 1'b1);
		rd_chk(ga(6), 32'h5555_5678);
		rd_chk(REG_IP, exp_ip);
		// A write while the clock enable is low must leave the register untouched.
		@(posedge ref_clk);
		ce <= 1'b0;
		wr(ga(7), 32'h0000_00ff);
		ce <= 1'b1;
		rd_chk(ga(7), 32'h0);
		// A second reset in mid-run clears the architectural state.
		@(posedge ref_clk);
		sys_rst <= 1'b1;
		@(posedge ref_clk);
		sys_rst <= 1'b0;
		rd_chk(ga(3), 32'h0);
		rd_chk(REG_IP, 32'h0);
		print_verdict();
	end
endmodule
